// [logic/duf_fifo.sv]
`timescale 1ns/1ps

module duf_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] count;
    } duf_fifo_s;

    duf_fifo_s fifo_reg;
    duf_fifo_s fifo_next;
    logic push;
    logic pop;

    // Handshakes straight from the fill level
    assign in_ready = fifo_reg.count != (AW+1)'(D);
    assign out_valid = fifo_reg.count != '0;
    assign out_data = fifo_reg.mem[fifo_reg.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer wrap relies on a power-of-two depth
    always_comb begin
        fifo_next = fifo_reg;
        if (push) begin
            fifo_next.mem[fifo_reg.wp] = in_data;
            fifo_next.wp = fifo_reg.wp + 1'b1;
        end
        if (pop) begin
            fifo_next.rp = fifo_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            fifo_next.count = fifo_reg.count + 1'b1;
        end else if (pop && !push) begin
            fifo_next.count = fifo_reg.count - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fifo_reg <= '0;
        end else begin
            fifo_reg <= fifo_next;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (rst)
        fifo_reg.count <= (AW+1)'(D))
        else $error("fifo count above depth");

endmodule : duf_fifo

// [logic/duf_rx.sv]
`timescale 1ns/1ps
`include "duf_params.svh"

module duf_rx #(
    parameter int BIT_CYC = 1736
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic serial_in,
    input wire logic rd,
    output logic [7:0] data,
    output logic valid,
    output logic overrun
);
    localparam logic [15:0] HALF_M1 = 16'(BIT_CYC / 2 - 1);
    localparam logic [15:0] BIT_M1 = 16'(BIT_CYC - 1);

    duf_pkg::duf_rx_s rx_reg;
    duf_pkg::duf_rx_s rx_next;

    assign data = rx_reg.data;
    assign valid = rx_reg.valid;
    assign overrun = rx_reg.overrun;

    // Start edge, mid-bit sampling, stop check
    always_comb begin
        rx_next = rx_reg;
        rx_next.overrun = 1'b0;
        if (rd) begin
            rx_next.valid = 1'b0;
        end
        unique case (rx_reg.state)
            duf_pkg::duf_rx_idle: begin
                if (serial_in == `DUF_LINE_START) begin
                    rx_next.state = duf_pkg::duf_rx_start;
                    rx_next.cnt = HALF_M1;
                end
            end
            duf_pkg::duf_rx_start: begin
                if (rx_reg.cnt != '0) begin
                    rx_next.cnt = rx_reg.cnt - 1'b1;
                end else if (serial_in != `DUF_LINE_START) begin
                    // Glitch shorter than half a bit
                    rx_next.state = duf_pkg::duf_rx_idle;
                end else begin
                    rx_next.state = duf_pkg::duf_rx_data;
                    rx_next.cnt = BIT_M1;
                    rx_next.idx = '0;
                end
            end
            duf_pkg::duf_rx_data: begin
                if (rx_reg.cnt != '0) begin
                    rx_next.cnt = rx_reg.cnt - 1'b1;
                end else begin
                    rx_next.shift = {serial_in, rx_reg.shift[7:1]};
                    rx_next.cnt = BIT_M1;
                    rx_next.idx = rx_reg.idx + 1'b1;
                    if (rx_reg.idx == `DUF_LAST_BIT) begin
                        rx_next.state = duf_pkg::duf_rx_stop;
                    end
                end
            end
            duf_pkg::duf_rx_stop: begin
                if (rx_reg.cnt != '0) begin
                    rx_next.cnt = rx_reg.cnt - 1'b1;
                end else begin
                    rx_next.state = duf_pkg::duf_rx_idle;
                    if (serial_in == `DUF_LINE_IDLE) begin
                        rx_next.overrun = rx_reg.valid && !rd;
                        rx_next.data = rx_reg.shift;
                        rx_next.valid = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_reg <= '{state: duf_pkg::duf_rx_idle, default: '0};
        end else begin
            rx_reg <= rx_next;
        end
    end

    rx_deliver_a: assert property (@(posedge clk) disable iff (rst)
        (rx_reg.state == duf_pkg::duf_rx_stop && rx_reg.cnt == '0 && serial_in)
        |=> (valid && data == $past(rx_reg.shift)))
        else $error("good stop bit did not deliver character");

endmodule : duf_rx

// [logic/duf_top.sv]
`timescale 1ns/1ps
`include "duf_params.svh"

module duf_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic std_flow_en,
    input wire logic std_port_serial_in,
    output logic std_port_serial_out,
    input wire logic std_port_send_permit,
    output logic std_port_rx_room,
    input wire logic [7:0] std_tx_data,
    input wire logic std_tx_valid,
    output logic std_tx_ready,
    output logic [7:0] std_rx_data,
    output logic std_rx_valid,
    input wire logic std_rx_read,
    output logic std_rx_overrun,
    input wire logic fast_flow_en,
    input wire logic fast_port_serial_in,
    output logic fast_port_serial_out,
    input wire logic fast_port_send_permit,
    output logic fast_port_rx_room,
    input wire logic [7:0] fast_tx_data,
    input wire logic fast_tx_valid,
    output logic fast_tx_ready,
    output logic [7:0] fast_rx_data,
    output logic fast_rx_valid,
    input wire logic fast_rx_read,
    output logic fast_rx_overrun
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-port views, index 0 standard, 1 fast

    logic [1:0] flow_en;
    logic [1:0] permit;
    logic [1:0] ser_in;
    logic [1:0] ser_out;
    logic [1:0] room;
    logic [1:0] tx_valid;
    logic [1:0] tx_ready;
    logic [1:0][7:0] tx_data;
    logic [1:0][7:0] rx_data;
    logic [1:0] rx_valid;
    logic [1:0] rx_read;
    logic [1:0] rx_overrun;
    logic [1:0] fifo_valid;
    logic [1:0] fifo_ready;
    logic [1:0][7:0] fifo_data;
    duf_pkg::duf_tx_s [1:0] tx_reg;
    duf_pkg::duf_tx_s [1:0] tx_next;

    // Shared assertion clock and reset
    default clocking duf_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Gather pins into arrays
    assign flow_en = {fast_flow_en, std_flow_en};
    assign permit = {fast_port_send_permit, std_port_send_permit};
    assign ser_in = {fast_port_serial_in, std_port_serial_in};
    assign tx_valid = {fast_tx_valid, std_tx_valid};
    assign tx_data = {fast_tx_data, std_tx_data};
    assign rx_read = {fast_rx_read, std_rx_read};

    // Scatter results back to pins
    assign std_port_serial_out = ser_out[0];
    assign fast_port_serial_out = ser_out[1];
    assign std_port_rx_room = room[0];
    assign fast_port_rx_room = room[1];
    assign std_tx_ready = tx_ready[0];
    assign fast_tx_ready = tx_ready[1];

    // Receive side results
    assign std_rx_data = rx_data[0];
    assign fast_rx_data = rx_data[1];
    assign std_rx_valid = rx_valid[0];
    assign fast_rx_valid = rx_valid[1];
    assign std_rx_overrun = rx_overrun[0];
    assign fast_rx_overrun = rx_overrun[1];

    ////////////////////////////////////////////////////////////////////////////
    // two independent ports

    for (genvar i = 0; i < 2; i++) begin : g_port
        localparam int BIT_CYC = (i == 0) ? `DUF_STD_BIT_CYC : `DUF_FAST_BIT_CYC;
        localparam logic [15:0] BIT_M1 = 16'(BIT_CYC - 1);

        // Transmit buffer stalls the processor side when full
        duf_fifo #(
            .W(`DUF_DATA_BITS),
            .D(`DUF_FIFO_DEPTH)
        ) u_tx_fifo (
            .clk(clk),
            .rst(rst),
            .in_valid(tx_valid[i]),
            .in_ready(tx_ready[i]),
            .in_data(tx_data[i]),
            .out_valid(fifo_valid[i]),
            .out_ready(fifo_ready[i]),
            .out_data(fifo_data[i])
        );

        duf_rx #(
            .BIT_CYC(BIT_CYC)
        ) u_rx (
            .clk(clk),
            .rst(rst),
            .serial_in(ser_in[i]),
            .rd(rx_read[i]),
            .data(rx_data[i]),
            .valid(rx_valid[i]),
            .overrun(rx_overrun[i])
        );

        // room only meaningful with flow control
        assign room[i] = flow_en[i] ? !rx_valid[i] : 1'b1;

        // Shift register loads only when the transmitter is free
        assign fifo_ready[i] = tx_reg[i].state == duf_pkg::duf_tx_idle;
        assign ser_out[i] = tx_reg[i].line;

        // Transmit sequencer: load, hold for permit, then frame out
        always_comb begin
            tx_next[i] = tx_reg[i];
            unique case (tx_reg[i].state)
                duf_pkg::duf_tx_idle: begin
                    if (fifo_valid[i]) begin
                        tx_next[i].shift = fifo_data[i];
                        tx_next[i].state = duf_pkg::duf_tx_hold;
                    end
                end
                duf_pkg::duf_tx_hold: begin
                    if (!flow_en[i] || permit[i]) begin
                        tx_next[i].state = duf_pkg::duf_tx_start;
                        tx_next[i].cnt = BIT_M1;
                        tx_next[i].line = `DUF_LINE_START;
                    end
                end
                duf_pkg::duf_tx_start: begin
                    if (tx_reg[i].cnt != '0) begin
                        tx_next[i].cnt = tx_reg[i].cnt - 1'b1;
                    end else begin
                        tx_next[i].state = duf_pkg::duf_tx_data;
                        tx_next[i].cnt = BIT_M1;
                        tx_next[i].idx = '0;
                        tx_next[i].line = tx_reg[i].shift[0];
                    end
                end
                duf_pkg::duf_tx_data: begin
                    if (tx_reg[i].cnt != '0) begin
                        tx_next[i].cnt = tx_reg[i].cnt - 1'b1;
                    end else if (tx_reg[i].idx == `DUF_LAST_BIT) begin
                        tx_next[i].state = duf_pkg::duf_tx_stop;
                        tx_next[i].cnt = BIT_M1;
                        tx_next[i].line = `DUF_LINE_IDLE;
                    end else begin
                        tx_next[i].cnt = BIT_M1;
                        tx_next[i].idx = tx_reg[i].idx + 1'b1;
                        tx_next[i].shift = {1'b0, tx_reg[i].shift[7:1]};
                        tx_next[i].line = tx_reg[i].shift[1];
                    end
                end
                duf_pkg::duf_tx_stop: begin
                    // Full stop bit before the next frame may load
                    if (tx_reg[i].cnt != '0) begin
                        tx_next[i].cnt = tx_reg[i].cnt - 1'b1;
                    end else begin
                        tx_next[i].state = duf_pkg::duf_tx_idle;
                    end
                end
            endcase
        end

        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                tx_reg[i] <= '{state: duf_pkg::duf_tx_idle, line: `DUF_LINE_IDLE, default: '0};
            end else begin
                tx_reg[i] <= tx_next[i];
            end
        end

        ////////////////////////////////////////////////////////////////////////
        // Checks per port

        tx_load_a: assert property (@(posedge clk) disable iff (rst)
            (tx_reg[i].state == duf_pkg::duf_tx_idle && fifo_valid[i])
            |=> (tx_reg[i].state == duf_pkg::duf_tx_hold && tx_reg[i].shift == $past(fifo_data[i])))
            else $error("waiting character not loaded");

        tx_line_a: assert property (@(posedge clk) disable iff (rst)
            (tx_reg[i].state == duf_pkg::duf_tx_start) |-> !ser_out[i])
            else $error("start bit not low");

        tx_start_a: assert property (@(posedge clk) disable iff (rst)
            (tx_reg[i].state == duf_pkg::duf_tx_hold && (permit[i] || !flow_en[i]))
            |=> (tx_reg[i].state == duf_pkg::duf_tx_start && !ser_out[i]))
            else $error("permitted frame did not start");

        tx_hold_a: assert property (@(posedge clk) disable iff (rst)
            (tx_reg[i].state == duf_pkg::duf_tx_hold && flow_en[i] && !permit[i])
            |=> (tx_reg[i].state == duf_pkg::duf_tx_hold && ser_out[i]
                && $stable(tx_reg[i].shift)))
            else $error("frame left hold without permit");

        frame_keep_a: assert property (@(posedge clk) disable iff (rst)
            (tx_reg[i].state inside {duf_pkg::duf_tx_start, duf_pkg::duf_tx_data})
            |=> !(tx_reg[i].state inside {duf_pkg::duf_tx_hold, duf_pkg::duf_tx_idle}))
            else $error("frame cut short mid transfer");

        room_flow_a: assert property (@(posedge clk) disable iff (rst)
            flow_en[i] |-> (room[i] == !rx_valid[i]))
            else $error("room does not track unread character");

        room_off_a: assert property (@(posedge clk) disable iff (rst)
            !flow_en[i] |-> room[i])
            else $error("room dropped with flow control off");

        tx_stop_a: assert property (
            tx_reg[i].state == duf_pkg::duf_tx_stop |-> ser_out[i])
            else $error("stop bit not high");

        tx_bit_a: assert property (
            tx_reg[i].state == duf_pkg::duf_tx_data |-> ser_out[i] == tx_reg[i].shift[0])
            else $error("data bit wrong on line");

        tx_idle_a: assert property (
            tx_reg[i].state inside {duf_pkg::duf_tx_idle, duf_pkg::duf_tx_hold} |-> ser_out[i])
            else $error("line low outside a frame");

        rx_keep_a: assert property (
            rx_valid[i] && !rx_read[i] |=> rx_valid[i])
            else $error("unread character lost");

        rx_hold_a: assert property (
            rx_valid[i] && !rx_read[i] |=> rx_overrun[i] || $stable(rx_data[i]))
            else $error("unread character changed silently");

        overrun_a: assert property (
            rx_overrun[i] |-> rx_valid[i])
            else $error("overrun without a character");

        hold_cov: cover property (@(posedge clk) disable iff (rst)
            tx_reg[i].state == duf_pkg::duf_tx_hold ##1
            tx_reg[i].state == duf_pkg::duf_tx_hold ##1
            tx_reg[i].state == duf_pkg::duf_tx_start);

        rx_cov: cover property (@(posedge clk) disable iff (rst)
            !rx_valid[i] ##1 rx_valid[i]);

        full_cov: cover property (@(posedge clk) disable iff (rst)
            tx_valid[i] && !tx_ready[i]);

        over_cov: cover property (rx_overrun[i]);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cross-port independence

    // Fast port held by its own permit even when the standard one is granted
    fast_own_a: assert property (@(posedge clk) disable iff (rst)
        (tx_reg[1].state == duf_pkg::duf_tx_hold && fast_flow_en && !fast_port_send_permit
            && std_port_send_permit)
        |=> tx_reg[1].state == duf_pkg::duf_tx_hold)
        else $error("fast port followed standard permit");

    // Fast room follows only its own receive register
    fast_room_a: assert property (@(posedge clk) disable iff (rst)
        (fast_flow_en && std_rx_valid && !fast_rx_valid) |-> fast_port_rx_room)
        else $error("fast room followed standard port");

    // Standard room follows only its own receive register
    std_room_a: assert property (
        (std_flow_en && fast_rx_valid && !std_rx_valid) |-> std_port_rx_room)
        else $error("standard room followed fast port");

    own_cov: cover property (
        tx_reg[1].state == duf_pkg::duf_tx_hold && !fast_port_send_permit && std_port_send_permit);

endmodule : duf_top

// [pkg/duf_params.svh]
`ifndef DUF_PARAMS_SVH
`define DUF_PARAMS_SVH

// Core clock and line rates, in hertz and baud
`define DUF_CLK_HZ 200000000
`define DUF_STD_BAUD 115200
`define DUF_FAST_BAUD 921600

// Bit period in clock cycles, rounded down
`define DUF_STD_BIT_CYC (`DUF_CLK_HZ / `DUF_STD_BAUD)
`define DUF_FAST_BIT_CYC (`DUF_CLK_HZ / `DUF_FAST_BAUD)

// Character and buffer shape
`define DUF_DATA_BITS 8
`define DUF_LAST_BIT 3'h7
`define DUF_FIFO_DEPTH 8

// Line levels
`define DUF_LINE_IDLE 1'b1
`define DUF_LINE_START 1'b0

`endif

// [pkg/duf_pkg.sv]
package duf_pkg;

    // Transmitter states, one-hot
    typedef enum logic [4:0] {
        duf_tx_idle = 5'h01,
        duf_tx_hold = 5'h02,
        duf_tx_start = 5'h04,
        duf_tx_data = 5'h08,
        duf_tx_stop = 5'h10
    } duf_tx_e;

    // Receiver states, one-hot
    typedef enum logic [3:0] {
        duf_rx_idle = 4'h1,
        duf_rx_start = 4'h2,
        duf_rx_data = 4'h4,
        duf_rx_stop = 4'h8
    } duf_rx_e;

    typedef struct packed {
        duf_tx_e state;
        logic [7:0] shift;
        logic [2:0] idx;
        logic [15:0] cnt;
        logic line;
    } duf_tx_s;

    typedef struct packed {
        duf_rx_e state;
        logic [7:0] shift;
        logic [2:0] idx;
        logic [15:0] cnt;
        logic [7:0] data;
        logic valid;
        logic overrun;
    } duf_rx_s;

endpackage : duf_pkg

// [tb/duf_remote.sv]
`timescale 1ns/1ps

////////////////////////////////////////
// Far end of one serial port: sends characters on request, collects frames seen on the line
module duf_remote #(
    parameter int BIT = 217
) (
    input wire logic clk,
    input wire logic flow_en,
    input wire logic rx_room,
    input wire logic line_in,
    output logic line_out,
    output logic permit
);
    logic [7:0] rx_q[$];
    int frame_errs;

    // Line idles high, permit starts withheld
    initial begin
        line_out = 1'b1;
        permit = 1'b0;
        frame_errs = 0;
    end

    task automatic set_permit(input logic v);
        @(negedge clk);
        permit = v;
    endtask : set_permit

    // One 8N1 frame, LSB first, changed on falling edges only
    task automatic send_char(input logic [7:0] c);
        int w;
        logic [9:0] f;
        w = 0;
        f = {1'b1, c, 1'b0};
        while (flow_en === 1'b1 && rx_room !== 1'b1 && w < 100000) begin
            @(negedge clk);
            w++;
        end
        for (int i = 0; i < 10; i++) begin
            @(negedge clk);
            line_out = f[i];
            repeat (BIT - 1) @(negedge clk);
        end
    endtask : send_char

    // Mid-bit sampling; a low stop bit is kept as a framing fault, not a character
    always begin : rx_frames
        logic [7:0] b;
        @(negedge line_in);
        repeat (BIT / 2) @(posedge clk);
        if (line_in === 1'b0) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk);
                b = {line_in, b[7:1]};
            end
            repeat (BIT) @(posedge clk);
            if (line_in === 1'b1) rx_q.push_back(b);
            else frame_errs++;
        end
    end
endmodule : duf_remote

// [tb/tb.sv]
`timescale 1ns/1ps
`include "duf_params.svh"

module tb;
    localparam int SB = `DUF_STD_BIT_CYC;
    localparam int FB = `DUF_FAST_BIT_CYC;
    // Ceiling well above the roughly 51k cycles the sequence needs
    localparam int LIMIT = 90000;

    logic clk, rst, std_flow_en, fast_flow_en, std_tx_valid, fast_tx_valid, std_rx_read, fast_rx_read;
    logic [7:0] std_tx_data, fast_tx_data;
    logic std_in, std_out, std_permit, std_room, std_tx_ready, std_rx_valid, std_rx_overrun;
    logic fast_in, fast_out, fast_permit, fast_room, fast_tx_ready, fast_rx_valid, fast_rx_overrun;
    logic [7:0] std_rx_data, fast_rx_data;
    int bad_count, tests_run, cycles, n;
    logic ok;

    duf_top i_dut (.clk(clk), .rst(rst), .std_flow_en(std_flow_en), .std_port_serial_in(std_in),
        .std_port_serial_out(std_out), .std_port_send_permit(std_permit), .std_port_rx_room(std_room),
        .std_tx_data(std_tx_data), .std_tx_valid(std_tx_valid), .std_tx_ready(std_tx_ready),
        .std_rx_data(std_rx_data), .std_rx_valid(std_rx_valid), .std_rx_read(std_rx_read),
        .std_rx_overrun(std_rx_overrun), .fast_flow_en(fast_flow_en), .fast_port_serial_in(fast_in),
        .fast_port_serial_out(fast_out), .fast_port_send_permit(fast_permit), .fast_port_rx_room(fast_room),
        .fast_tx_data(fast_tx_data), .fast_tx_valid(fast_tx_valid), .fast_tx_ready(fast_tx_ready),
        .fast_rx_data(fast_rx_data), .fast_rx_valid(fast_rx_valid), .fast_rx_read(fast_rx_read),
        .fast_rx_overrun(fast_rx_overrun));
    duf_remote #(.BIT(SB)) i_std_far (.clk(clk), .flow_en(std_flow_en), .rx_room(std_room),
        .line_in(std_out), .line_out(std_in), .permit(std_permit));
    duf_remote #(.BIT(FB)) i_fast_far (.clk(clk), .flow_en(fast_flow_en), .rx_room(fast_room),
        .line_in(fast_out), .line_out(fast_in), .permit(fast_permit));

    ////////////////////////////////////////
    // Clock and hang guard
    always #2.5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            bad_count++;
            $display("BAD t=%0t run exceeded cycle ceiling", $time);
            final_report();
        end
    end

    task automatic check(input logic c, input string msg);
        tests_run++;
        if (c !== 1'b1) begin
            bad_count++;
            $display("BAD t=%0t %s", $time, msg);
        end
    endtask : check

    // One push into an empty transmit buffer
    task automatic push(input logic sel, input logic [7:0] d);
        @(negedge clk);
        if (sel) begin
            fast_tx_data = d;
            fast_tx_valid = 1'b1;
        end else begin
            std_tx_data = d;
            std_tx_valid = 1'b1;
        end
        @(negedge clk);
        fast_tx_valid = 1'b0;
        std_tx_valid = 1'b0;
    endtask : push

    // Cycles until a start bit shows, bounded
    task automatic wait_start(input logic sel, input int lim, output int k);
        k = 0;
        while ((sel ? fast_out : std_out) !== 1'b0 && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask : wait_start

    task automatic hold_high(input logic sel, input int len, input string msg);
        logic h;
        h = 1'b1;
        repeat (len) begin
            @(negedge clk);
            if ((sel ? fast_out : std_out) !== 1'b1) h = 1'b0;
        end
        check(h, msg);
    endtask : hold_high

    task automatic wait_fast_q(input int cnt, input int lim);
        int k;
        k = 0;
        while (i_fast_far.rx_q.size() < cnt && k < lim) begin
            @(negedge clk);
            k++;
        end
    endtask : wait_fast_q

    task automatic read_rx(input logic sel);
        @(negedge clk);
        if (sel) fast_rx_read = 1'b1;
        else std_rx_read = 1'b1;
        @(negedge clk);
        fast_rx_read = 1'b0;
        std_rx_read = 1'b0;
    endtask : read_rx

    ////////////////////////////////////////
    // Scenarios
    task automatic t_fill_and_hold();
        int acc;
        acc = 0;
        // Permit withheld: one frame parks in the shift register, eight more fill the buffer
        repeat (14) begin
            @(negedge clk);
            fast_tx_data = 8'h40 + acc[7:0];
            fast_tx_valid = 1'b1;
            #1;
            if (fast_tx_ready === 1'b1) begin
                @(posedge clk);
                acc++;
            end
        end
        @(negedge clk);
        fast_tx_valid = 1'b0;
        check(acc == 9, "buffer did not refuse after nine characters");
        hold_high(1'b1, 300, "frame left without permit");
        i_fast_far.set_permit(1'b1);
        wait_start(1'b1, 10, n);
        check(n <= 3, "no start bit soon after permit");
        repeat (2 * FB) @(negedge clk);
        i_fast_far.set_permit(1'b0);
        wait_fast_q(1, 12 * FB);
        check(i_fast_far.rx_q.size() == 1 && i_fast_far.rx_q[0] === 8'h40, "frame cut by permit drop");
        hold_high(1'b1, 3 * FB, "second frame sent without permit");
        i_fast_far.set_permit(1'b1);
        wait_fast_q(9, 9 * 12 * FB);
        ok = (i_fast_far.rx_q.size() == 9);
        for (int i = 0; i < 9 && ok; i++) if (i_fast_far.rx_q[i] !== 8'h40 + i[7:0]) ok = 1'b0;
        check(ok, "drained characters wrong or out of order");
        $display("test fill_and_hold done");
    endtask : t_fill_and_hold

    task automatic t_receive_room();
        i_fast_far.send_char(8'ha5);
        check(fast_rx_valid === 1'b1 && fast_rx_data === 8'ha5, "fast character not received");
        check(fast_room === 1'b0, "room shown while character unread");
        fork
            i_fast_far.send_char(8'h5a);
        join_none
        repeat (3 * FB) @(negedge clk);
        check(fast_rx_data === 8'ha5, "held character overwritten");
        read_rx(1'b1);
        check(fast_rx_valid === 1'b0 && fast_room === 1'b1, "read did not free register");
        n = 0;
        while (fast_rx_valid !== 1'b1 && n < 12 * FB) begin
            @(negedge clk);
            n++;
        end
        check(fast_rx_data === 8'h5a, "second fast character wrong");
        read_rx(1'b1);
        $display("test receive_room done");
    endtask : t_receive_room

    task automatic t_flow_off();
        // Permit withheld so the flow-off frame proves it is ignored
        i_fast_far.set_permit(1'b0);
        fast_flow_en = 1'b0;
        i_fast_far.send_char(8'h81);
        check(fast_rx_valid === 1'b1 && fast_room === 1'b1, "room not forced with flow off");
        // Second character lands on the unread one
        fork
            i_fast_far.send_char(8'h82);
            for (n = 0; n < 11 * FB && fast_rx_overrun !== 1'b1; n++) @(negedge clk);
        join
        check(n < 11 * FB && fast_rx_data === 8'h82, "overrun not flagged");
        read_rx(1'b1);
        push(1'b1, 8'h18);
        wait_start(1'b1, 10, n);
        check(n <= 4, "transmitter waited on permit with flow off");
        wait_fast_q(10, 12 * FB);
        check(i_fast_far.rx_q.size() == 10 && i_fast_far.rx_q[9] === 8'h18, "flow-off frame wrong");
        @(negedge clk);
        fast_flow_en = 1'b1;
        $display("test flow_off done");
    endtask : t_flow_off

    task automatic t_std_port();
        // Fast frame parked behind its own withheld permit while the standard pair runs
        push(1'b1, 8'h77);
        i_std_far.set_permit(1'b1);
        fork
            push(1'b0, 8'h3c);
            i_std_far.send_char(8'hc3);
            hold_high(1'b1, 11 * SB, "fast port followed standard permit");
        join
        check(std_rx_valid === 1'b1 && std_rx_data === 8'hc3, "standard character not received");
        check(std_room === 1'b0 && fast_room === 1'b1, "room pair not independent");
        check(i_std_far.rx_q.size() == 1 && i_std_far.rx_q[0] === 8'h3c, "standard frame wrong");
        std_flow_en = 1'b0;
        @(negedge clk);
        check(std_room === 1'b1, "standard room not forced with flow off");
        std_flow_en = 1'b1;
        read_rx(1'b0);
        check(std_room === 1'b1, "standard room not restored");
        check(i_std_far.frame_errs == 0 && i_fast_far.frame_errs == 0, "bad stop bit seen");
        $display("test std_port done");
    endtask : t_std_port

    ////////////////////////////////////////
    // Verdict and end of run
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report

    // Inputs settle at time zero; reset held four cycles
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        std_flow_en = 1'b1;
        fast_flow_en = 1'b1;
        std_tx_valid = 1'b0;
        fast_tx_valid = 1'b0;
        std_rx_read = 1'b0;
        fast_rx_read = 1'b0;
        std_tx_data = 8'h00;
        fast_tx_data = 8'h00;
        bad_count = 0;
        tests_run = 0;
        cycles = 0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        check(std_out === 1'b1 && fast_out === 1'b1 && std_room === 1'b1 && fast_room === 1'b1
            && fast_tx_ready === 1'b1 && std_rx_valid === 1'b0, "reset state wrong");
        t_fill_and_hold();
        t_receive_room();
        t_flow_off();
        t_std_port();
        final_report();
    end
endmodule : tb
